// ### include/rss_pkg.sv
// reset_startup_sequencer package: register map, field positions, reset values, timing
// assumes a 40 MHz hclk; the power-up timer and pin filter counts below are derived from that rate
package rss_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 25;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_PWR_CTRL = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_WDT_PERIOD = 8'h0C;
  // status fields
  localparam int ST_WDT_EXPIRED = 0;
  localparam int ST_SLEEP_ENTRY = 1;
  localparam int ST_CORE_RESET_N = 2;
  localparam int ST_PIN_HOLD = 3;
  localparam int ST_SEQ_LSB = 4;
  // power control fields
  localparam int PC_SW_RESET_N = 0;
  localparam int PC_STACK_FULL = 1;
  localparam int PC_STACK_EMPTY = 2;
  localparam int PC_BROWNOUT_N = 3;
  localparam int PC_POWERON_N = 4;
  localparam int PC_WIDTH = 5;
  // configuration fields
  localparam int CF_STACK_FAULT_EN = 0;
  localparam int CF_STARTUP_DELAY_EN_N = 1;
  localparam int CF_PIN_ENABLE = 2;
  localparam int CF_LOW_VOLT_PROG = 3;
  localparam int CF_OSC_NEEDED = 4;
  localparam int CF_WDT_ENABLE = 5;
  localparam int CF_LOW_POWER_DET_EN = 6;
  localparam int CF_WIDTH = 7;
  // reset values
  localparam logic [PC_WIDTH-1:0] PWR_CTRL_RESET = 5'h0F;
  localparam logic [CF_WIDTH-1:0] CONFIG_RESET = 7'h34;
  localparam logic [15:0] WDT_PERIOD_RESET = 16'hFFFF;
  // timing
  localparam int PWRT_TIME_US = 64;
  localparam int PWRT_CYCLES = (PWRT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int OST_CYCLES = 1024;
  localparam int PIN_FILTER_NS = 200;
  localparam int PIN_FILTER_CYCLES = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUPPLY_FILTER_CYCLES = 1;
  localparam int HOLD_CYCLES = 4;
  // sequencer states
  typedef enum logic [3:0] {
    SEQ_RUN = 4'b0001,
    SEQ_HOLD = 4'b0010,
    SEQ_START = 4'b0100,
    SEQ_PIN = 4'b1000
  } rss_state_t;
endpackage

// ### logic/rss_level_filter.sv
// two-flop synchroniser followed by a stability filter
// assumes raw comes from outside the hclk domain
`timescale 1ns/100ps
module rss_level_filter #(
  parameter int STABLE_CYCLES = 8,
  parameter logic RESET_LEVEL = 1'b0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // level in and filtered level out
  input wire logic raw,
  output logic level
);
  localparam int CW = $clog2(STABLE_CYCLES + 1);
  logic sync_a;
  logic sync_b;
  logic [CW-1:0] cnt;
  wire differs = (sync_b != level);
  wire stable = (cnt == CW'(STABLE_CYCLES - 1));

  initial begin
    if (STABLE_CYCLES < 1) $error("rss_level_filter: STABLE_CYCLES must be at least 1");
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= RESET_LEVEL;
      sync_b <= RESET_LEVEL;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  // level follows only after the new value held for the whole window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      level <= RESET_LEVEL;
    end else if (!differs) begin
      cnt <= '0;
    end else if (stable) begin
      cnt <= '0;
      level <= sync_b;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end
endmodule

// ### logic/rss_timer.sv
// start-up timer: counts up to CYCLES after restart falls, then reports done
// assumes restart is a level on hclk
`timescale 1ns/100ps
module rss_timer #(
  parameter int CYCLES = 1024
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic restart,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt;

  initial begin
    if (CYCLES < 1) $error("rss_timer: CYCLES must be at least 1");
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
    end else if (restart) begin
      cnt <= '0;
    end else if (cnt != CW'(CYCLES)) begin
      cnt <= cnt + CW'(1);
    end
  end

  assign done = (cnt == CW'(CYCLES));
endmodule

// ### logic/rss_sequencer.sv
// reset_startup_sequencer: gathers reset sources, records causes, sequences core release
// assumes one AHB-Lite master, core event pulses on hclk, supply and pin levels asynchronous
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
//
// Overview of operation
// [RULE_01] watchdog resets core unless cleared in time
// [RULE_02] watchdog reset sets expired, clears sleep flag
// [RULE_03] software reset instruction fully resets core
// [RULE_04] software reset clears software_reset_flag_n to zero
// [RULE_05] stack overflow or underflow can reset core
// [RULE_06] separate stack full and empty flags
// [RULE_07] stack resets only when enable bit set
// [RULE_08] programming exit behaves like power-on reset
// [RULE_09] power-up timer optionally delays start after supply
// [RULE_10] active-low enable bit selects power-up delay
// [RULE_11] start waits timers and released reset pin
// [RULE_12] timers keep counting while pin held low
// [RULE_13] timers expired: start at once on pin release
// [RULE_14] low-power detector ORed into brown-out reset
// [RULE_15] pin enabled by programming bit or enable
// [RULE_16] held pin keeps reset; pin never driven
// [RULE_17] pin glitches filtered out
// [RULE_18] timer lengths are parameters, restarted on supply events
module rss_sequencer #(
  parameter int PWRT_CYCLES = rss_pkg::PWRT_CYCLES,
  parameter int OST_CYCLES = rss_pkg::OST_CYCLES,
  parameter int PIN_FILTER_CYCLES = rss_pkg::PIN_FILTER_CYCLES,
  parameter int HOLD_CYCLES = rss_pkg::HOLD_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // core events
  input wire logic clear_watchdog_instruction,
  input wire logic reset_instruction,
  input wire logic sleep_instruction,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire logic programming_exit,
  // supply and pin levels
  input wire logic poweron_event,
  input wire logic brownout_event,
  input wire logic low_power_brownout_detector,
  input wire logic external_reset_pin_n,
  // core reset
  output logic core_reset_n
);
  import rss_pkg::*;

  localparam int HW = $clog2(HOLD_CYCLES + 1);

  initial begin
    if (HOLD_CYCLES < 1) $error("rss_sequencer: HOLD_CYCLES must be at least 1");
  end

  // ahb-lite slave
  logic wr_pend;
  logic rd_pend;
  logic [7:0] addr_q;
  wire take = hsel && hready && htrans[1];
  wire wr_power_control = wr_pend && (addr_q == OFS_PWR_CTRL);
  wire wr_config = wr_pend && (addr_q == OFS_CONFIG);
  wire wr_period = wr_pend && (addr_q == OFS_WDT_PERIOD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend <= take && hwrite;
      rd_pend <= take && !hwrite;
      if (take) addr_q <= {haddr[7:2], 2'b00};
    end
  end

  // registers
  logic [CF_WIDTH-1:0] config_reg;
  logic [PC_WIDTH-1:0] power_control_register;
  logic [15:0] wdt_period;
  logic watchdog_expired_flag;
  logic sleep_entry_flag;
  rss_state_t state;
  rss_state_t next_state;

  wire stack_fault_reset_enable = config_reg[CF_STACK_FAULT_EN];
  wire startup_delay_enable_n = config_reg[CF_STARTUP_DELAY_EN_N];
  wire external_reset_pin_enable = config_reg[CF_PIN_ENABLE];
  wire low_voltage_programming = config_reg[CF_LOW_VOLT_PROG];
  wire osc_needed = config_reg[CF_OSC_NEEDED];
  wire wdt_enable = config_reg[CF_WDT_ENABLE];
  wire low_power_det_enable = config_reg[CF_LOW_POWER_DET_EN];

  // synchronised and filtered inputs
  logic pin_level;
  logic por_s;
  logic bor_s;
  logic low_power_s;

  rss_level_filter #(.STABLE_CYCLES(PIN_FILTER_CYCLES), .RESET_LEVEL(1'b1)) u_pin ( // [RULE_17]
    .hclk(hclk), .hresetn(hresetn), .raw(external_reset_pin_n), .level(pin_level));
  rss_level_filter #(.STABLE_CYCLES(SUPPLY_FILTER_CYCLES), .RESET_LEVEL(1'b0)) u_por (
    .hclk(hclk), .hresetn(hresetn), .raw(poweron_event), .level(por_s));
  rss_level_filter #(.STABLE_CYCLES(SUPPLY_FILTER_CYCLES), .RESET_LEVEL(1'b0)) u_bor (
    .hclk(hclk), .hresetn(hresetn), .raw(brownout_event), .level(bor_s));
  rss_level_filter #(.STABLE_CYCLES(SUPPLY_FILTER_CYCLES), .RESET_LEVEL(1'b0)) u_low_power (
    .hclk(hclk), .hresetn(hresetn), .raw(low_power_brownout_detector), .level(low_power_s));

  // reset sources
  wire brownout_reset = bor_s || (low_power_s && low_power_det_enable); // [RULE_14]
  wire poweron_like = por_s || programming_exit; // [RULE_08]
  wire supply_evt = poweron_like || brownout_reset;
  wire pin_enabled = external_reset_pin_enable || low_voltage_programming; // [RULE_15]
  wire pin_hold = pin_enabled && !pin_level; // [RULE_16]
  wire stack_full_evt = stack_overflow && stack_fault_reset_enable; // [RULE_07]
  wire stack_empty_evt = stack_underflow && stack_fault_reset_enable; // [RULE_07]
  wire stack_evt = stack_full_evt || stack_empty_evt; // [RULE_05]
  logic wdt_fire;
  wire core_evt = wdt_fire || reset_instruction || stack_evt; // [RULE_03]

  // watchdog
  logic [15:0] wdt_count;
  wire wdt_clear = clear_watchdog_instruction || !core_reset_n || !wdt_enable;
  assign wdt_fire = wdt_enable && core_reset_n && !clear_watchdog_instruction
                    && (wdt_count == wdt_period); // [RULE_01]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wdt_count <= 16'h0000;
    else if (wdt_clear || wdt_fire) wdt_count <= 16'h0000;
    else wdt_count <= wdt_count + 16'h0001;
  end

  // start-up timers restart on every supply event, ignore the pin
  logic pwrt_done;
  logic ost_done;
  rss_timer #(.CYCLES(PWRT_CYCLES)) u_pwrt ( // [RULE_18] [RULE_12]
    .hclk(hclk), .hresetn(hresetn), .restart(supply_evt), .done(pwrt_done));
  rss_timer #(.CYCLES(OST_CYCLES)) u_ost ( // [RULE_18] [RULE_12]
    .hclk(hclk), .hresetn(hresetn), .restart(supply_evt), .done(ost_done));

  wire pwrt_ok = pwrt_done || startup_delay_enable_n; // [RULE_10] [RULE_09]
  wire ost_ok = ost_done || !osc_needed;
  wire start_ready = pwrt_ok && ost_ok && !pin_hold; // [RULE_11] [RULE_13]

  // sequencer
  logic [HW-1:0] hold_cnt;
  wire hold_done = (hold_cnt == HW'(HOLD_CYCLES - 1));

  always_comb begin
    next_state = state;
    case (state)
      SEQ_RUN: begin
        if (core_evt) next_state = SEQ_HOLD;
        else if (pin_hold) next_state = SEQ_PIN;
      end
      SEQ_HOLD: begin
        if (hold_done) next_state = pin_hold ? SEQ_PIN : SEQ_RUN;
      end
      SEQ_START: begin
        if (start_ready) next_state = SEQ_RUN; // [RULE_13]
      end
      SEQ_PIN: begin
        if (!pin_hold) next_state = SEQ_RUN;
      end
      default: next_state = SEQ_START;
    endcase
    if (supply_evt) next_state = SEQ_START; // [RULE_09]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SEQ_START;
      hold_cnt <= '0;
      core_reset_n <= 1'b0;
    end else begin
      state <= next_state;
      hold_cnt <= (state == SEQ_HOLD) ? hold_cnt + HW'(1) : '0;
      core_reset_n <= (next_state == SEQ_RUN);
    end
  end

  // status flags: watchdog expiry wins over clears, clears win over sleep entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_expired_flag <= 1'b0;
      sleep_entry_flag <= 1'b0;
    end else if (wdt_fire) begin
      watchdog_expired_flag <= 1'b1; // [RULE_02]
      sleep_entry_flag <= 1'b0; // [RULE_02]
    end else if (poweron_like || clear_watchdog_instruction) begin
      watchdog_expired_flag <= 1'b0;
      sleep_entry_flag <= 1'b0;
    end else if (sleep_instruction) begin
      sleep_entry_flag <= 1'b1;
    end
  end

  // power control register: software write, then hardware overrides
  logic [PC_WIDTH-1:0] next_power_control_register;
  always_comb begin
    next_power_control_register = power_control_register;
    if (wr_power_control) next_power_control_register = hwdata[PC_WIDTH-1:0];
    if (reset_instruction) next_power_control_register[PC_SW_RESET_N] = 1'b0; // [RULE_04]
    if (stack_full_evt) next_power_control_register[PC_STACK_FULL] = 1'b1; // [RULE_06]
    if (stack_empty_evt) next_power_control_register[PC_STACK_EMPTY] = 1'b1; // [RULE_06]
    if (brownout_reset) next_power_control_register[PC_BROWNOUT_N] = 1'b0; // [RULE_14]
    if (poweron_like) next_power_control_register[PC_POWERON_N] = 1'b0; // [RULE_08]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_control_register <= PWR_CTRL_RESET;
      config_reg <= CONFIG_RESET;
      wdt_period <= WDT_PERIOD_RESET;
    end else begin
      power_control_register <= next_power_control_register;
      if (wr_config) config_reg <= hwdata[CF_WIDTH-1:0];
      if (wr_period) wdt_period <= hwdata[15:0];
    end
  end

  // read data, one wait state
  wire [31:0] status_word = {24'h000000, state, pin_hold, core_reset_n,
                             sleep_entry_flag, watchdog_expired_flag};
  wire [31:0] rd_mux = (addr_q == OFS_STATUS) ? status_word :
                       (addr_q == OFS_PWR_CTRL) ? {27'h0, power_control_register} :
                       (addr_q == OFS_CONFIG) ? {25'h0, config_reg} :
                       (addr_q == OFS_WDT_PERIOD) ? {16'h0000, wdt_period} : 32'h00000000;
  logic rd_wait;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      rd_wait <= rd_pend && !rd_wait;
      if (rd_pend && !rd_wait) hrdata <= rd_mux;
    end
  end

  assign hreadyout = !(rd_pend && !rd_wait);
  assign hresp = 1'b0;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_quiet;
    !supply_evt && !core_evt;
  endsequence

  sequence s_start_ok;
    state == SEQ_START && start_ready;
  endsequence

  a_wdt_resets: assert property (wdt_fire |=> !core_reset_n [*3]) // [RULE_01]
    else $error("watchdog expiry did not hold core in reset");
  a_wdt_flags: assert property (wdt_fire |=> // [RULE_02]
    watchdog_expired_flag && !sleep_entry_flag)
    else $error("watchdog flags not updated");
  a_swrst_hold: assert property (reset_instruction |=> // [RULE_03]
    !core_reset_n ##1 !core_reset_n)
    else $error("software reset did not reset core");
  a_swrst_flag: assert property (reset_instruction |=> // [RULE_04]
    !power_control_register[PC_SW_RESET_N])
    else $error("software reset flag not cleared");
  a_stack_flag: assert property (stack_overflow && stack_fault_reset_enable |=> // [RULE_06]
    power_control_register[PC_STACK_FULL] && !core_reset_n)
    else $error("stack full reset not recorded");
  a_stack_empty: assert property (stack_underflow && stack_fault_reset_enable |=> // [RULE_06]
    power_control_register[PC_STACK_EMPTY] && !core_reset_n)
    else $error("stack empty reset not recorded");
  a_stack_gate: assert property (state == SEQ_RUN // [RULE_07]
    && (stack_overflow || stack_underflow)
    && !stack_fault_reset_enable && !wdt_fire && !reset_instruction && !supply_evt
    && !pin_hold |=> core_reset_n)
    else $error("stack fault reset while disabled");
  a_prog_exit: assert property (programming_exit |=> state == SEQ_START // [RULE_08]
    && !power_control_register[PC_POWERON_N])
    else $error("programming exit not treated as power-on");
  a_supply_start: assert property (supply_evt |=> state == SEQ_START // [RULE_09]
    && !core_reset_n)
    else $error("supply event did not restart the sequence");
  a_pwrt_hold: assert property (state == SEQ_START && !pwrt_done // [RULE_09]
    && !startup_delay_enable_n |=> !core_reset_n)
    else $error("core released before power-up timer");
  a_start_release: assert property (s_start_ok and s_quiet // [RULE_13]
    |=> core_reset_n && state == SEQ_RUN)
    else $error("core not released when start conditions met");
  a_pin_holds: assert property (pin_hold |=> !core_reset_n) // [RULE_16]
    else $error("core running while reset pin held");
  a_low_power_or: assert property (low_power_s && low_power_det_enable // [RULE_14]
    |=> state == SEQ_START && !power_control_register[PC_BROWNOUT_N])
    else $error("low-power brown-out not acting as brown-out");
endmodule

// ### verif/rss_far_side.sv
// far side model: core that runs instructions, reset pin with pull-up
// assumes op is set by the bench for one cycle just after a rising edge
`timescale 1ns/100ps
module rss_far_side (
  // clock and core state
  input wire logic hclk,
  input wire logic core_reset_n,
  // bench commands
  input wire logic [2:0] op,
  input wire logic kick_en,
  input wire logic pin_low,
  // core events
  output logic clear_watchdog_instruction,
  output logic reset_instruction,
  output logic sleep_instruction,
  output logic stack_overflow,
  output logic stack_underflow,
  output logic programming_exit,
  // reset pin
  output logic external_reset_pin_n
);
  logic [1:0] kick_cnt = 2'h0;
  wire run = core_reset_n === 1'b1;
  always @(posedge hclk) begin
    kick_cnt <= kick_cnt + 2'h1;
  end
  // instructions and stack events only run while the core is out of reset; programming exit does not wait for it
  assign clear_watchdog_instruction = run && kick_en && kick_cnt == 2'h3;
  assign reset_instruction = run && op == 3'h1;
  assign sleep_instruction = run && op == 3'h2;
  assign stack_overflow = run && op == 3'h3;
  assign stack_underflow = run && op == 3'h4;
  assign programming_exit = op == 3'h5;
  // pulled up when released, only the outside pulls it low
  assign external_reset_pin_n = !pin_low;
endmodule

// ### verif/test_reset_startup_sequencer.sv
// testbench for the reset and start-up sequencer
// assumes rss_far_side as the core and pin, short timer parameters
`timescale 1ns/100ps
module test_reset_startup_sequencer;
  import rss_pkg::*;
  localparam int PWRT = 20;
  localparam int OST = 10;
  localparam int PF = 2;
  localparam int HOLD = 4;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, core_reset_n, r;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, op, sup;
  logic kick_en, pin_low, poweron_event, brownout_event, low_power_brownout_detector;
  logic clear_watchdog_instruction, reset_instruction, sleep_instruction;
  logic stack_overflow, stack_underflow, programming_exit, external_reset_pin_n;
  int mismatches, total_checks, n;
  assign hready = hreadyout;
  assign poweron_event = sup[0];
  assign brownout_event = sup[1];
  assign low_power_brownout_detector = sup[2];
  rss_sequencer #(.PWRT_CYCLES(PWRT), .OST_CYCLES(OST), .PIN_FILTER_CYCLES(PF),
    .HOLD_CYCLES(HOLD)) i_rss_sequencer (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
    .clear_watchdog_instruction, .reset_instruction, .sleep_instruction,
    .stack_overflow, .stack_underflow, .programming_exit, .poweron_event,
    .brownout_event, .low_power_brownout_detector, .external_reset_pin_n,
    .core_reset_n);
  rss_far_side i_rss_far_side (.hclk, .core_reset_n, .op, .kick_en, .pin_low,
    .clear_watchdog_instruction, .reset_instruction, .sleep_instruction,
    .stack_overflow, .stack_underflow, .programming_exit, .external_reset_pin_n);
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic end_sim;
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask
  // waits for ready sampled high at a falling edge, data taken there
  task automatic bus_wait(output logic [31:0] d);
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    d = hrdata;
    @(posedge hclk);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    bus_wait(rd);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    bus_wait(rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hFFFF_FFFF);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e & m);
  endtask
  // one-cycle core event, returns the core reset level after its edge
  task automatic pulse(input logic [2:0] code, output logic lvl);
    op <= code;
    @(posedge hclk);
    op <= 3'h0;
    @(negedge hclk);
    lvl = core_reset_n;
    @(posedge hclk);
  endtask
  // counts cycles until core_reset_n reaches lvl, lim if it never does
  task automatic wait_core(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    @(negedge hclk);
    while (core_reset_n !== lvl && cnt < lim) begin
      cnt++;
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask
  task automatic supply(input logic [2:0] s);
    sup <= s;
    repeat (4) @(posedge hclk);
    sup <= 3'h0;
  endtask
  initial begin
    #(6000 * 25);
    mismatches++;
    end_sim;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    op = 3'h0;
    sup = 3'h0;
    kick_en = 1'b0;
    pin_low = 1'b0;
    mismatches = 0;
    total_checks = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    wait_core(1'b1, 200, n);
    ok(n >= OST && n < 200);
    // reset values, unmapped and read-only places
    rdchk(OFS_PWR_CTRL, 32'(PWR_CTRL_RESET));
    rdchk(OFS_CONFIG, 32'(CONFIG_RESET));
    rdchk(OFS_WDT_PERIOD, 32'(WDT_PERIOD_RESET));
    wr(8'h10, 32'hFFFF_FFFF);
    rdchk(8'h10, 32'h0);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rdchk(OFS_STATUS, 32'h14);
    ok(hresp === 1'b0);
    // watchdog kicked, then starved
    wr(OFS_WDT_PERIOD, 32'h10);
    pulse(3'h2, r);
    rdchk(OFS_STATUS, 32'h2, 32'h3);
    kick_en <= 1'b1;
    wait_core(1'b0, 60, n);
    ok(n == 60);
    kick_en <= 1'b0;
    wait_core(1'b0, 40, n);
    ok(n < 40);
    rdchk(OFS_STATUS, 32'h1, 32'h3);
    wr(OFS_CONFIG, 32'h14);
    wait_core(1'b1, 20, n);
    // software reset
    pulse(3'h1, r);
    ok(r === 1'b0);
    rdchk(OFS_PWR_CTRL, 32'h0, 32'h1);
    wait_core(1'b1, 20, n);
    ok(n <= HOLD + 4);
    // stack faults, disabled then enabled
    wr(OFS_PWR_CTRL, 32'h19);
    pulse(3'h3, r);
    ok(r === 1'b1);
    wr(OFS_CONFIG, 32'h15);
    pulse(3'h3, r);
    ok(r === 1'b0);
    rdchk(OFS_PWR_CTRL, 32'h2, 32'h6);
    wait_core(1'b1, 20, n);
    wr(OFS_PWR_CTRL, 32'h19);
    pulse(3'h4, r);
    ok(r === 1'b0);
    rdchk(OFS_PWR_CTRL, 32'h4, 32'h6);
    wait_core(1'b1, 20, n);
    // reset pin: glitch, hold, release, enable modes
    wr(OFS_CONFIG, 32'h14);
    pin_low <= 1'b1;
    @(posedge hclk);
    pin_low <= 1'b0;
    wait_core(1'b0, 12, n);
    ok(n == 12);
    pin_low <= 1'b1;
    wait_core(1'b0, 12, n);
    ok(n < 12);
    wait_core(1'b1, 10, n);
    ok(n == 10);
    pin_low <= 1'b0;
    wait_core(1'b1, 12, n);
    ok(n < 12);
    wr(OFS_CONFIG, 32'h10);
    pin_low <= 1'b1;
    wait_core(1'b0, 12, n);
    ok(n == 12);
    pin_low <= 1'b0;
    wr(OFS_CONFIG, 32'h18);
    pin_low <= 1'b1;
    wait_core(1'b0, 12, n);
    ok(n < 12);
    pin_low <= 1'b0;
    wait_core(1'b1, 20, n);
    // supply events with and without the power-up delay
    wr(OFS_CONFIG, 32'h14);
    wr(OFS_PWR_CTRL, 32'h1F);
    supply(3'b010);
    wait_core(1'b1, 200, n);
    ok(n >= PWRT && n < 200);
    rdchk(OFS_PWR_CTRL, 32'h10, 32'h18);
    wr(OFS_CONFIG, 32'h16);
    supply(3'b010);
    wait_core(1'b1, 200, n);
    ok(n >= OST && n < PWRT);
    wr(OFS_PWR_CTRL, 32'h1F);
    supply(3'b001);
    wait_core(1'b1, 200, n);
    ok(n >= OST && n < 200);
    rdchk(OFS_PWR_CTRL, 32'h08, 32'h18);
    wr(OFS_CONFIG, 32'h56);
    wr(OFS_PWR_CTRL, 32'h1F);
    supply(3'b100);
    wait_core(1'b1, 200, n);
    ok(n >= OST && n < 200);
    rdchk(OFS_PWR_CTRL, 32'h10, 32'h18);
    // programming exit acts as power-on
    wr(OFS_CONFIG, 32'h14);
    wr(OFS_PWR_CTRL, 32'h1F);
    pulse(3'h5, r);
    wait_core(1'b1, 200, n);
    ok(r === 1'b0 && n >= PWRT - 2 && n < 200);
    rdchk(OFS_PWR_CTRL, 32'h08, 32'h18);
    // pin held past both timers, then released
    pin_low <= 1'b1;
    supply(3'b010);
    wait_core(1'b1, 3 * PWRT, n);
    ok(n == 3 * PWRT);
    pin_low <= 1'b0;
    wait_core(1'b1, 20, n);
    ok(n <= PF + 4);
    end_sim;
  end
endmodule
